/* File: serial_port_zero_control_tb_top.sv */
// Self-checking testbench for serial port zero
`timescale 1ns/1ps
module serial_port_zero_control_tb_top;
  import spz_pkg::*;
  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [APB_AW-1:0]    paddr = '0;
  logic [APB_DW-1:0]    pwdata = '0;
  logic [APB_DW-1:0]    prdata;
  logic                 pready, pslverr, serial_data_i, serial_data_o, serial_data_oe_n;
  logic                 serial_txd, irq, serial_irq;
  logic                 baud_tick = 1'b0;
  logic [3:0]           tk = 4'h0;
  logic [31:0]          rd;
  logic [7:0]           d;
  logic                 err, ok, n9;
  int                   miscompares = 0;
  int                   checks_done = 0;
  // {control, mask, data, ninth, accepted}
  logic [25:0]          rx_tab [5] = '{{8'hb0, 8'hf0, 8'h5a, 2'b00}, {8'hb0, 8'hf0, 8'h6a, 2'b10},
    {8'hb0, 8'hf0, 8'h5a, 2'b11}, {8'hb0, 8'h00, 8'h6a, 2'b11}, {8'ha0, 8'h00, 8'h33, 2'b10}};

  spz_serial_port dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick(baud_tick), .serial_data_i(serial_data_i),
    .serial_data_o(serial_data_o), .serial_data_oe_n(serial_data_oe_n),
    .serial_txd(serial_txd), .irq(irq), .serial_irq(serial_irq));
  spz_remote u_peer (.clk(clk), .serial_txd(serial_txd), .serial_data_o(serial_data_o),
    .serial_data_oe_n(serial_data_oe_n), .serial_data_i(serial_data_i));

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    tk <= tk + 4'h1;
    baud_tick <= (tk == 4'hf);
  end

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    xfer(1'b1, idx, v);
  endtask

  task automatic rdm(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rd & m, exp);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdm(IDX_CONTROL, 32'hffffffff, 32'h0);
    rdm(IDX_MATCH_ADDR, 32'hffffffff, 32'h0);
    rdm(8'h10, 32'hffffffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(IDX_EVT_MASK, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_IRQ_ENABLE, i[0] ? 8'h10 : 8'h90);
      wr(IDX_POWER, i[0] ? 8'h80 : 8'h00);
      wr(IDX_CONTROL, i[0] ? 8'h80 : 8'h88);
      fork
        wr(IDX_BUFFER, 8'ha5 ^ 8'(i));
        u_peer.recv(d, n9, ok, i[0] ? 32 : 64);
      join
      chk({ok, n9, d}, {1'b1, ~i[0], 8'ha5 ^ 8'(i)});
      rdm(IDX_CONTROL, 32'hffffffff, i[0] ? 32'h82 : 32'h8a);
      chk({31'h0, serial_irq}, {31'h0, ~i[0]});
      chk({31'h0, irq}, 32'h1);
      wr(IDX_EVT_STATUS, 8'h01);
      wr(IDX_CONTROL, 8'h80);
      // Let the stop bit finish before the next frame
      repeat (64) @(posedge clk);
      chk({30'h0, irq, serial_irq}, 32'h0);
    end
    // Mode 0 transmit with the fast shift clock on the transmit line
    wr(IDX_CONTROL, 8'h20);
    fork
      wr(IDX_BUFFER, 8'h96);
      u_peer.shift_in(d, ok, 4);
    join
    chk({ok, d}, {1'b1, 8'h96});
    rdm(IDX_CONTROL, 32'h2, 32'h2);
    repeat (8) @(posedge clk);
    chk({31'h0, serial_data_oe_n}, 32'h1);
    wr(IDX_POWER, 8'h00);
    wr(IDX_MATCH_ADDR, 8'h50);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_MATCH_MASK, rx_tab[k][17:10]);
      wr(IDX_CONTROL, rx_tab[k][25:18]);
      u_peer.send(rx_tab[k][9:2], rx_tab[k][1], 1'b1, 64);
      rdm(IDX_CONTROL, rx_tab[k][0] ? 32'h5 : 32'h1, rx_tab[k][0] ? 32'h5 : 32'h0);
      if (rx_tab[k][0]) rdm(IDX_BUFFER, 32'hffffffff, {24'h0, rx_tab[k][9:2]});
    end
    wr(IDX_POWER, 8'h40);
    wr(IDX_CONTROL, 8'h10);
    u_peer.send(8'h44, 1'b0, 1'b0, 64);
    rdm(IDX_CONTROL, 32'h80, 32'h80);
    rdm(IDX_EVT_STATUS, 32'h4, 32'h4);
    wr(IDX_CONTROL, 8'h10);
    rdm(IDX_CONTROL, 32'h80, 32'h0);
    wr(IDX_POWER, 8'h00);
    rdm(IDX_CONTROL, 32'h80, 32'h80);
    // Mode 1 on the baud tick: bad stop dropped with multiprocessor set
    for (int k = 0; k < 2; k++) begin
      wr(IDX_CONTROL, k[0] ? 8'h50 : 8'h70);
      u_peer.send(8'h3c, k[0], 1'b1, 256);
      rdm(IDX_CONTROL, 32'h5, k[0] ? 32'h5 : 32'h0);
      if (k[0]) rdm(IDX_BUFFER, 32'hffffffff, 32'h3c);
    end
    report_and_stop();
  end
endmodule // serial_port_zero_control_tb_top

bind spz_serial_port spz_serial_port_chk u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_txd(serial_txd), .serial_data_oe_n(serial_data_oe_n), .irq(irq),
  .serial_irq(serial_irq));

/* File: spz_pkg.sv */
// Package of register map, field positions, reset values and timing for serial port zero
package spz_pkg;

  localparam int          APB_AW          = 12;
  localparam int          APB_DW          = 32;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0]  IDX_CONTROL     = 8'h98;
  localparam logic [7:0]  IDX_BUFFER      = 8'h99;
  localparam logic [7:0]  IDX_MATCH_ADDR  = 8'ha9;
  localparam logic [7:0]  IDX_MATCH_MASK  = 8'hb9;
  localparam logic [7:0]  IDX_POWER       = 8'h87;
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'ha8;
  localparam logic [7:0]  IDX_EVT_STATUS  = 8'hf0;
  localparam logic [7:0]  IDX_EVT_MASK    = 8'hf1;

  // Serial control fields
  localparam int          CTL_MODE0_FE    = 7;
  localparam int          CTL_MODE1       = 6;
  localparam int          CTL_MULTIPROC   = 5;
  localparam int          CTL_RX_ENABLE   = 4;
  localparam int          CTL_TX_NINTH    = 3;
  localparam int          CTL_RX_NINTH    = 2;
  localparam int          CTL_TX_DONE     = 1;
  localparam int          CTL_RX_DONE     = 0;

  // Power control, interrupt enable and event status fields
  localparam int          PWR_RATE_DOUBLE = 7;
  localparam int          PWR_FE_SELECT   = 6;
  localparam int          IEN_GLOBAL      = 7;
  localparam int          IEN_SERIAL      = 4;
  localparam int          EVT_TX          = 0;
  localparam int          EVT_RX          = 1;
  localparam int          EVT_FE          = 2;
  localparam int          EVT_W           = 3;

  // Reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT    = 3'h0;

  // Modes as {mode_bit0, mode_bit1}
  localparam logic [1:0]  MODE_0          = 2'h0;
  localparam logic [1:0]  MODE_1          = 2'h1;
  localparam logic [1:0]  MODE_2          = 2'h2;

  // Timing in oscillator clocks; the oscillator is clk itself
  localparam int          OSC_PER_CLK     = 1;
  localparam int          OVERSAMPLE      = 16;
  localparam int          M2_BIT_SLOW_TCLK = 64;
  localparam int          M2_BIT_FAST_TCLK = 32;
  localparam int          M0_BIT_SLOW_TCLK = 12;
  localparam int          M0_BIT_FAST_TCLK = 4;
  localparam logic [1:0]  M2_TICK_SLOW_LAST =
    2'(M2_BIT_SLOW_TCLK * OSC_PER_CLK / OVERSAMPLE - 1);
  localparam logic [1:0]  M2_TICK_FAST_LAST =
    2'(M2_BIT_FAST_TCLK * OSC_PER_CLK / OVERSAMPLE - 1);
  localparam logic [3:0]  M0_SLOW_LAST    = 4'(M0_BIT_SLOW_TCLK * OSC_PER_CLK - 1);
  localparam logic [3:0]  M0_FAST_LAST    = 4'(M0_BIT_FAST_TCLK * OSC_PER_CLK - 1);
  localparam logic [3:0]  M0_SLOW_HALF    = 4'(M0_BIT_SLOW_TCLK * OSC_PER_CLK / 2);
  localparam logic [3:0]  M0_FAST_HALF    = 4'(M0_BIT_FAST_TCLK * OSC_PER_CLK / 2);
  localparam logic [3:0]  SUB_MID         = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0]  SUB_LAST        = 4'(OVERSAMPLE - 1);
  localparam logic [3:0]  STOP_IDX_10BIT  = 4'h9;
  localparam logic [3:0]  STOP_IDX_11BIT  = 4'ha;
  localparam logic [3:0]  M0_LAST_BIT     = 4'h7;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SYNC  = 2'b10
  } spz_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_ASYNC = 2'b01,
    RX_SYNC  = 2'b10
  } spz_rx_state_t;

  function automatic logic [APB_AW-1:0] spz_reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

/* File: spz_remote.sv */
// Remote serial device model on the transmit line and the data pin
`timescale 1ns/1ps
module spz_remote (
  input  wire logic clk,
  input  wire logic serial_txd,
  input  wire logic serial_data_o,
  input  wire logic serial_data_oe_n,
  output logic      serial_data_i
);
  logic drv = 1'b1;
  // Pulled-up pin; the block wins while it drives
  assign serial_data_i = serial_data_oe_n ? drv : serial_data_o;

  task automatic send(input logic [7:0] d, input logic n9, input logic stp, input int bclk);
    logic [10:0] f;
    f = {stp, n9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      drv <= f[i];
      repeat (bclk) @(posedge clk);
    end
    drv <= 1'b1;
  endtask

  // Mode 0 sink: takes a bit at each rising shift clock; ok needs the pin
  // driven by the block and every later bit exactly bclk long
  task automatic shift_in(output logic [7:0] d, output logic ok, input int bclk);
    int   n;
    logic prev;
    logic rise;
    d = 8'h00;
    ok = 1'b1;
    prev = 1'b1;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
        rise = !prev && serial_txd === 1'b1;
        prev = serial_txd;
      end while (!rise && n < 400);
      d[i] = serial_data_o;
      if (!rise || serial_data_oe_n !== 1'b0 || (i > 0 && n != bclk)) ok = 1'b0;
    end
  endtask

  // Samples each bit at its middle; ok is the stop bit level
  task automatic recv(output logic [7:0] d, output logic n9, output logic ok, input int bclk);
    int n;
    n = 0;
    d = 8'h00;
    n9 = 1'b0;
    ok = 1'b0;
    while (serial_txd === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n < 400) begin
      repeat (bclk / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bclk) @(posedge clk);
        if (i < 8) d[i] = serial_txd;
        else n9 = serial_txd;
      end
      repeat (bclk) @(posedge clk);
      ok = serial_txd;
    end
  endtask
endmodule // spz_remote

/* File: spz_serial_port.sv */
// Serial port zero: shift and asynchronous modes with an APB register slave
//
// Summary of operation
// - Control bit 7 is mode bit or frame error
// - Bad stop bit sets sticky frame error flag
// - Mode bits pick shift, 10-bit or 11-bit frames
// - Mode 2 bit is 64 or 32 clocks
// - Multiprocessor modes 2/3 drop frames with ninth zero
// - Multiprocessor mode 1 needs a valid stop
// - Mode 0 shift clock is clk/12 or clk/4
// - Reception only while receive enable is set
// - Modes 2/3 send software ninth bit
// - Receive ninth bit holds ninth or stop bit
// - Transmit done timing; software clears only
// - Receive done timing; software clears only
// - Buffer reads receive data, writes transmit data
// - Port interrupt needs both enable bits
// - Only mask-enabled bits compared to match address
// - All-zero mask accepts any address
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module spz_serial_port
  import spz_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire logic [spz_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [spz_pkg::APB_DW-1:0] pwdata,
  output logic      [spz_pkg::APB_DW-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      baud_tick,
  input  wire logic                      serial_data_i,
  output logic                           serial_data_o,
  output logic                           serial_data_oe_n,
  output logic                           serial_txd,
  output logic                           irq,
  output logic                           serial_irq
);

  typedef struct packed {
    logic [7:0]          ctl;
    logic                fe;
    logic [7:0]          rx_buf;
    logic [7:0]          maddr;
    logic [7:0]          mmask;
    logic [7:0]          power;
    logic [7:0]          irq_en;
    logic [EVT_W-1:0]    evt;
    logic [EVT_W-1:0]    evt_mask;
    spz_tx_state_t       tx_st;
    logic [3:0]          tx_cnt;
    logic [3:0]          tx_sub;
    logic [10:0]         tx_sh;
    spz_rx_state_t       rx_st;
    logic [3:0]          rx_cnt;
    logic [3:0]          rx_sub;
    logic [8:0]          rx_sh;
    logic                rxd_prev;
    logic                txd;
    logic                dat_o;
    logic                dat_oe_n;
    logic [APB_DW-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
    logic                serial_irq;
  } spz_state_t;

  spz_state_t q;
  spz_state_t n;

  logic       rxd_s;
  logic       m2_tick;

  logic [1:0] mode;
  logic       mp;
  logic       nine;
  logic [3:0] m0_last;
  logic [3:0] m0_half;
  logic [3:0] stop_idx;
  logic       tick16;
  logic       sel_ctl;
  logic       sel_buf;
  logic       sel_maddr;
  logic       sel_mmask;
  logic       sel_pwr;
  logic       sel_ien;
  logic       sel_evt;
  logic       sel_emask;
  logic       hit;
  logic [7:0] rd_val;
  logic       acc;
  logic       wr;
  logic       set_ti;
  logic       set_ri;
  logic       set_fe;
  logic [7:0] rx_data;
  logic       rx_ninth;
  logic       rx_match;
  logic       rx_accept;

  spz_sync u_rxd_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .din     (serial_data_i),
    .dout    (rxd_s)
  );

  spz_tick_gen u_m2_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .fast    (q.power[PWR_RATE_DOUBLE]),
    .tick    (m2_tick)
  );

  always_comb begin
    n         = q;
    mode      = {q.ctl[CTL_MODE0_FE], q.ctl[CTL_MODE1]};
    mp        = q.ctl[CTL_MULTIPROC];
    nine      = mode[1];
    m0_last   = mp ? M0_FAST_LAST : M0_SLOW_LAST;
    m0_half   = mp ? M0_FAST_HALF : M0_SLOW_HALF;
    stop_idx  = nine ? STOP_IDX_11BIT : STOP_IDX_10BIT;
    tick16    = (mode == MODE_2) ? m2_tick : baud_tick;
    set_ti    = 1'b0;
    set_ri    = 1'b0;
    set_fe    = 1'b0;
    rx_data   = 8'h00;
    rx_ninth  = 1'b0;
    rx_match  = 1'b0;
    rx_accept = 1'b0;

    // Address decode
    sel_ctl   = (paddr == spz_reg_addr(IDX_CONTROL));
    sel_buf   = (paddr == spz_reg_addr(IDX_BUFFER));
    sel_maddr = (paddr == spz_reg_addr(IDX_MATCH_ADDR));
    sel_mmask = (paddr == spz_reg_addr(IDX_MATCH_MASK));
    sel_pwr   = (paddr == spz_reg_addr(IDX_POWER));
    sel_ien   = (paddr == spz_reg_addr(IDX_IRQ_ENABLE));
    sel_evt   = (paddr == spz_reg_addr(IDX_EVT_STATUS));
    sel_emask = (paddr == spz_reg_addr(IDX_EVT_MASK));
    hit = sel_ctl | sel_buf | sel_maddr | sel_mmask | sel_pwr | sel_ien | sel_evt | sel_emask;

    rd_val = 8'h00;
    if (sel_ctl) begin
      rd_val = q.ctl;
      rd_val[CTL_MODE0_FE] = q.power[PWR_FE_SELECT] ? q.fe : q.ctl[CTL_MODE0_FE];
    end else if (sel_buf) begin
      rd_val = q.rx_buf;
    end else if (sel_maddr) begin
      rd_val = q.maddr;
    end else if (sel_mmask) begin
      rd_val = q.mmask;
    end else if (sel_pwr) begin
      rd_val = q.power;
    end else if (sel_ien) begin
      rd_val = q.irq_en;
    end else if (sel_evt) begin
      rd_val = {5'h00, q.evt};
    end else if (sel_emask) begin
      rd_val = {5'h00, q.evt_mask};
    end

    // One wait-free access cycle: answer prepared during setup
    acc = psel & penable & q.pready;
    wr  = acc & pwrite & ~q.pslverr;
    if (psel & ~penable) begin
      n.pready  = 1'b1;
      n.pslverr = ~hit;
      n.prdata  = hit ? {24'h000000, rd_val} : 32'h00000000;
    end else if (acc) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end

    if (wr) begin
      if (sel_ctl) begin
        n.ctl[6:0] = pwdata[6:0];
        if (q.power[PWR_FE_SELECT]) begin
          n.fe = pwdata[CTL_MODE0_FE];
        end else begin
          n.ctl[CTL_MODE0_FE] = pwdata[CTL_MODE0_FE];
        end
      end
      if (sel_maddr) begin
        n.maddr = pwdata[7:0];
      end
      if (sel_mmask) begin
        n.mmask = pwdata[7:0];
      end
      if (sel_pwr) begin
        n.power = pwdata[7:0];
      end
      if (sel_ien) begin
        n.irq_en = pwdata[7:0];
      end
      if (sel_emask) begin
        n.evt_mask = pwdata[EVT_W-1:0];
      end
      if (sel_evt) begin
        n.evt = q.evt & ~pwdata[EVT_W-1:0];
      end
      // A write while a transmit frame or a mode 0 receive is running is dropped
      if (sel_buf && q.tx_st == TX_IDLE && q.rx_st != RX_SYNC) begin
        n.tx_sub = 4'h0;
        n.tx_cnt = 4'h0;
        if (mode == MODE_0) begin
          n.tx_sh = {3'b111, pwdata[7:0]};
          n.tx_st = TX_SYNC;
        end else begin
          n.tx_sh = {1'b1, nine ? q.ctl[CTL_TX_NINTH] : 1'b1, pwdata[7:0], 1'b0};
          n.tx_st = TX_ASYNC;
        end
      end
    end

    // Transmitter
    unique case (q.tx_st)
      TX_IDLE: begin
      end
      TX_ASYNC: begin
        if (tick16) begin
          n.tx_sub = q.tx_sub + 4'h1;
          if (q.tx_sub == SUB_LAST) begin
            n.tx_sh  = {1'b1, q.tx_sh[10:1]};
            n.tx_cnt = q.tx_cnt + 4'h1;
            if (q.tx_cnt + 4'h1 == stop_idx) begin
              set_ti = 1'b1;
            end
            if (q.tx_cnt == stop_idx) begin
              n.tx_st = TX_IDLE;
            end
          end
        end
      end
      TX_SYNC: begin
        n.tx_sub = q.tx_sub + 4'h1;
        if (q.tx_sub >= m0_last) begin
          n.tx_sub = 4'h0;
          n.tx_sh  = {1'b1, q.tx_sh[10:1]};
          n.tx_cnt = q.tx_cnt + 4'h1;
          if (q.tx_cnt == M0_LAST_BIT) begin
            set_ti  = 1'b1;
            n.tx_st = TX_IDLE;
          end
        end
      end
      default: begin
        n.tx_st = TX_IDLE;
      end
    endcase

    // Receiver
    n.rxd_prev = rxd_s;
    unique case (q.rx_st)
      RX_IDLE: begin
        n.rx_sub = 4'h0;
        n.rx_cnt = 4'h0;
        if (q.ctl[CTL_RX_ENABLE]) begin
          if (mode != MODE_0 && q.rxd_prev && !rxd_s) begin
            n.rx_st = RX_ASYNC;
          end else if (mode == MODE_0 && !q.ctl[CTL_RX_DONE] && q.tx_st == TX_IDLE) begin
            n.rx_st = RX_SYNC;
          end
        end
      end
      RX_ASYNC: begin
        if (tick16) begin
          n.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == SUB_MID) begin
            n.rx_cnt = q.rx_cnt + 4'h1;
            if (q.rx_cnt == 4'h0) begin
              // Start bit gone high again: treat as a glitch
              if (rxd_s) begin
                n.rx_st = RX_IDLE;
              end
            end else if (q.rx_cnt != stop_idx) begin
              n.rx_sh = {rxd_s, q.rx_sh[8:1]};
            end else begin
              n.rx_st  = RX_IDLE;
              rx_data  = nine ? q.rx_sh[7:0] : q.rx_sh[8:1];
              rx_ninth = nine ? q.rx_sh[8] : rxd_s;
              rx_match = ((rx_data ^ q.maddr) & q.mmask) == 8'h00;
              set_fe   = ~rxd_s;
              if (!mp) begin
                rx_accept = 1'b1;
              end else if (mode == MODE_1) begin
                rx_accept = rxd_s;
              end else begin
                rx_accept = rx_ninth & rx_match;
              end
              // Unread data is kept: no overwrite while done flag is up
              if (rx_accept && !q.ctl[CTL_RX_DONE]) begin
                n.rx_buf = rx_data;
                n.ctl[CTL_RX_NINTH] = rx_ninth;
                set_ri = 1'b1;
              end
            end
          end
        end
      end
      RX_SYNC: begin
        n.rx_sub = q.rx_sub + 4'h1;
        if (q.rx_sub == m0_half) begin
          n.rx_sh = {rxd_s, q.rx_sh[8:1]};
        end
        if (q.rx_sub >= m0_last) begin
          n.rx_sub = 4'h0;
          n.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt == M0_LAST_BIT) begin
            n.rx_buf = q.rx_sh[8:1];
            set_ri   = 1'b1;
            n.rx_st  = RX_IDLE;
          end
        end
      end
      default: begin
        n.rx_st = RX_IDLE;
      end
    endcase
    if (!q.ctl[CTL_RX_ENABLE]) begin
      n.rx_st = RX_IDLE;
    end

    // Hardware sets win over software clears
    if (set_ti) begin
      n.ctl[CTL_TX_DONE] = 1'b1;
    end
    if (set_ri) begin
      n.ctl[CTL_RX_DONE] = 1'b1;
    end
    if (set_fe) begin
      n.fe = 1'b1;
    end
    n.evt = n.evt | {set_fe, set_ri, set_ti};

    // Pins: mode 0 drives the shift clock out, low in the first half bit
    if (n.tx_st == TX_SYNC) begin
      n.txd = n.tx_sub >= m0_half;
    end else if (n.rx_st == RX_SYNC) begin
      n.txd = n.rx_sub >= m0_half;
    end else if (n.tx_st == TX_ASYNC) begin
      n.txd = n.tx_sh[0];
    end else begin
      n.txd = 1'b1;
    end
    n.dat_o    = n.tx_sh[0];
    n.dat_oe_n = n.tx_st != TX_SYNC;

    n.irq        = |(n.evt & n.evt_mask);
    n.serial_irq = (n.ctl[CTL_TX_DONE] | n.ctl[CTL_RX_DONE])
                   & n.irq_en[IEN_SERIAL] & n.irq_en[IEN_GLOBAL];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{
        ctl: RST_BYTE, fe: 1'b0, rx_buf: RST_BYTE, maddr: RST_BYTE, mmask: RST_BYTE,
        power: RST_BYTE, irq_en: RST_BYTE, evt: RST_EVT, evt_mask: RST_EVT,
        tx_st: TX_IDLE, tx_cnt: 4'h0, tx_sub: 4'h0, tx_sh: 11'h7ff,
        rx_st: RX_IDLE, rx_cnt: 4'h0, rx_sub: 4'h0, rx_sh: 9'h000, rxd_prev: 1'b1,
        txd: 1'b1, dat_o: 1'b1, dat_oe_n: 1'b1, prdata: 32'h00000000,
        pready: 1'b0, pslverr: 1'b0, irq: 1'b0, serial_irq: 1'b0
      };
    end else if (ce) begin
      q <= n;
    end
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign serial_data_o    = q.dat_o;
  assign serial_data_oe_n = q.dat_oe_n;
  assign serial_txd       = q.txd;
  assign irq              = q.irq;
  assign serial_irq       = q.serial_irq;

endmodule // spz_serial_port

/* File: spz_serial_port_chk.sv */
// Port-level assertions for serial port zero
`timescale 1ns/1ps
module spz_serial_port_chk
  import spz_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        ce,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [spz_pkg::APB_DW-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        serial_txd,
  input wire logic                        serial_data_oe_n,
  input wire logic                        irq,
  input wire logic                        serial_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence setup_s;
    psel && !penable && ce;
  endsequence

  sequence answer_s;
    pready ##1 !pready;
  endsequence

  setup_answer_a: assert property (setup_s |=> answer_s)
    else $error("no single-cycle answer after setup");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready without a preceding setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error response outside access cycle");
  err_data_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("error response with nonzero data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  prdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data changed without a setup");
  reset_idle_a: assert property ($fell(sys_rst) |->
    serial_txd && serial_data_oe_n && !irq && !serial_irq && !pready)
    else $error("outputs not idle after reset");
  // Even the fast shift clock stays low for two cycles
  start_hold_a: assert property ($fell(serial_txd) |=> !serial_txd)
    else $error("transmit line low for a single cycle");
endmodule // spz_serial_port_chk

/* File: spz_sync.sv */
// Two-stage synchroniser for a pin input
`timescale 1ns/1ps
module spz_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } spz_sync_state_t;

  spz_sync_state_t q;
  spz_sync_state_t n;

  always_comb begin
    n    = q;
    n.s1 = din;
    n.s2 = q.s1;
  end

  // Idle line level is high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{s1: 1'b1, s2: 1'b1};
    end else if (ce) begin
      q <= n;
    end
  end

  assign dout = q.s2;
endmodule // spz_sync

/* File: spz_tick_gen.sv */
// Fixed-rate oversample tick for the fixed-rate asynchronous mode
`timescale 1ns/1ps
module spz_tick_gen
  import spz_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic fast,
  output logic      tick
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } spz_tick_state_t;

  spz_tick_state_t q;
  spz_tick_state_t n;
  logic [1:0]      last;

  always_comb begin
    n    = q;
    last = fast ? M2_TICK_FAST_LAST : M2_TICK_SLOW_LAST;
    n.tick = 1'b0;
    if (q.cnt >= last) begin
      n.cnt  = 2'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{cnt: 2'h0, tick: 1'b0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign tick = q.tick;
endmodule // spz_tick_gen
